// ### hdl/block_memory_params.svh
`ifndef BLOCK_MEMORY_PARAMS_SVH
`define BLOCK_MEMORY_PARAMS_SVH

// Register byte offsets on the APB.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LOAD_ADDR 8'h08
`define REG_LOAD_LO 8'h0C
`define REG_LOAD_HI 8'h10

// Control register fields and reset value.
`define CTRL_MODE_LSB 0
`define CTRL_ROM_BIT 2
`define CTRL_OUTREG_A_BIT 3
`define CTRL_OUTREG_B_BIT 4
`define CTRL_WMODE_A_LSB 5
`define CTRL_WMODE_B_LSB 7
`define CTRL_WSEL_A_LSB 9
`define CTRL_WSEL_B_LSB 12
`define CTRL_MASK 32'h0000_7FFF
`define CTRL_RESET 32'h0000_0000

// Status register fields.
`define STAT_CFG_BAD_BIT 0
`define STAT_COLLIDE_BIT 1

// Array geometry and port widths.
`define ARRAY_WORDS 256
`define ARRAY_WORD_BITS 36
`define ARRAY_BITS 9216
`define MAX_DEPTH 8192
`define LOAD_HI_BITS 4
`define WIDTH_X1 6'h01
`define WIDTH_X2 6'h02
`define WIDTH_X4 6'h04
`define WIDTH_X9 6'h09
`define WIDTH_X18 6'h12
`define WIDTH_X36 6'h24

`endif

// ### hdl/block_memory_pkg.sv
package block_memory_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_TRUE_DUAL = 2'b01,
        MODE_PSEUDO_DUAL = 2'b10
    } memMode_t;

    typedef enum logic [1:0] {
        WM_NORMAL = 2'b00,
        WM_THROUGH = 2'b01,
        WM_READ_FIRST = 2'b10
    } writeMode_t;

    typedef enum logic [2:0] {
        SEL_X1 = 3'b000,
        SEL_X2 = 3'b001,
        SEL_X4 = 3'b010,
        SEL_X9 = 3'b011,
        SEL_X18 = 3'b100,
        SEL_X36 = 3'b101
    } widthSel_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [12:0] addr;
        logic [35:0] wdata;
    } portReq_t;

endpackage : block_memory_pkg

// ### hdl/block_memory_array.sv
`include "block_memory_params.svh"

module block_memory_array #(
    parameter int WORDS = `ARRAY_WORDS,
    parameter int BITS = `ARRAY_WORD_BITS,
    parameter int AW = $clog2(WORDS)
) (
    // Clock and per-port latch clears
    input wire logic clk,
    input wire logic [1:0] clear,
    // Word accesses, index 0 is port A
    input wire logic [1:0] en,
    input wire logic [1:0] we,
    input wire logic [1:0][AW-1:0] addr,
    input wire logic [1:0][BITS-1:0] mask,
    input wire logic [1:0][BITS-1:0] wdata,
    input wire block_memory_pkg::writeMode_t [1:0] wMode,
    // Output latches
    output logic [1:0][BITS-1:0] rdata
);

    logic [BITS-1:0] mem [WORDS];
    logic [BITS-1:0] newA;
    logic [BITS-1:0] newB;

    // Port B merges over port A when both touch one word, so neither loses its bits.
    always_comb begin
        newA = (mem[addr[0]] & ~mask[0]) | (wdata[0] & mask[0]);
        newB = ((we[0] && addr[0] == addr[1]) ? newA : mem[addr[1]]) & ~mask[1];
        newB = newB | (wdata[1] & mask[1]);
    end

    always_ff @(posedge clk) begin
        if (en[0] && we[0]) begin
            mem[addr[0]] <= newA;
        end
        if (en[1] && we[1]) begin
            mem[addr[1]] <= newB;
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_latch
        logic [BITS-1:0] word_reg;
        logic [BITS-1:0] oldWord;
        logic [BITS-1:0] newWord;
        assign oldWord = mem[addr[p]];
        assign newWord = (p == 0) ? newA : newB;
        assign rdata[p] = word_reg;

        always_ff @(posedge clk or posedge clear[p]) begin
            if (clear[p]) begin
                word_reg <= '0;
            end else if (en[p] && !we[p]) begin
                word_reg <= oldWord;
            end else if (en[p]) begin
                case (wMode[p])
                    block_memory_pkg::WM_THROUGH: word_reg <= newWord;
                    block_memory_pkg::WM_READ_FIRST: word_reg <= oldWord;
                    default: word_reg <= word_reg;
                endcase
            end
        end

        a_normal_hold: assert property (@(posedge clk) disable iff (clear[p])
            en[p] && we[p] && wMode[p] == block_memory_pkg::WM_NORMAL |=> $stable(word_reg))
            else $error("latch changed on a normal-mode write");
        a_write_through: assert property (@(posedge clk) disable iff (clear[p])
            en[p] && we[p] && wMode[p] == block_memory_pkg::WM_THROUGH
            |=> (word_reg & $past(mask[p])) == ($past(wdata[p]) & $past(mask[p])))
            else $error("write-through did not show the written data");
        a_read_first: assert property (@(posedge clk) disable iff (clear[p])
            en[p] && we[p] && wMode[p] == block_memory_pkg::WM_READ_FIRST |=> word_reg == $past(oldWord))
            else $error("read-before-write did not show the old word");
    end

endmodule : block_memory_array

// ### hdl/embedded_block_memory.sv
`include "block_memory_params.svh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module embedded_block_memory #(
    parameter int APB_AW = 8
) (
    // Clock and chip-wide reset
    input wire logic clk,
    input wire logic reset_n,
    // Output latch resets, active high
    input wire logic portAOutputReset,
    input wire logic portBOutputReset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // User ports, index 0 is port A and 1 is port B
    input wire block_memory_pkg::portReq_t [1:0] portReq,
    output logic [1:0][35:0] dataOut,
    output logic [1:0] dataValid
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic [5:0] widthOf(input logic [2:0] sel);
        case (block_memory_pkg::widthSel_t'(sel))
            block_memory_pkg::SEL_X1: return `WIDTH_X1;
            block_memory_pkg::SEL_X2: return `WIDTH_X2;
            block_memory_pkg::SEL_X4: return `WIDTH_X4;
            block_memory_pkg::SEL_X9: return `WIDTH_X9;
            block_memory_pkg::SEL_X18: return `WIDTH_X18;
            default: return `WIDTH_X36;
        endcase
    endfunction : widthOf

    // Depth halves with each width step, so the address simply wraps at the depth.
    function automatic logic [12:0] depthMask(input logic [2:0] sel);
        logic [13:0] depth;
        depth = 14'(`MAX_DEPTH) >> sel;
        return 13'(depth - 14'h1);
    endfunction : depthMask

    function automatic logic [35:0] lowMask(input logic [5:0] width);
        logic [36:0] ones;
        ones = (37'h1 << width) - 37'h1;
        return ones[35:0];
    endfunction : lowMask

    function automatic logic regHit(input logic [APB_AW-1:0] a);
        return a == `REG_CTRL || a == `REG_STATUS || a == `REG_LOAD_ADDR
            || a == `REG_LOAD_LO || a == `REG_LOAD_HI;
    endfunction : regHit

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [31:0] ctrl_reg;
    logic [7:0] loadAddr_reg;
    logic [31:0] loadLo_reg;
    logic collide_reg;
    logic apbWrite;
    logic loadFire;
    logic cfgBad;
    logic romMode;
    logic collide;
    block_memory_pkg::memMode_t memMode;
    logic [1:0] outRegEn;
    block_memory_pkg::writeMode_t [1:0] wMode;
    logic [1:0][2:0] wSel;

    assign apbWrite = psel && penable && pwrite;
    assign loadFire = apbWrite && paddr == `REG_LOAD_HI;
    assign memMode = block_memory_pkg::memMode_t'(ctrl_reg[`CTRL_MODE_LSB +: 2]);
    assign romMode = ctrl_reg[`CTRL_ROM_BIT];
    assign outRegEn = {ctrl_reg[`CTRL_OUTREG_B_BIT], ctrl_reg[`CTRL_OUTREG_A_BIT]};
    assign wMode[0] = block_memory_pkg::writeMode_t'(ctrl_reg[`CTRL_WMODE_A_LSB +: 2]);
    assign wMode[1] = block_memory_pkg::writeMode_t'(ctrl_reg[`CTRL_WMODE_B_LSB +: 2]);
    assign wSel[0] = ctrl_reg[`CTRL_WSEL_A_LSB +: 3];
    assign wSel[1] = ctrl_reg[`CTRL_WSEL_B_LSB +: 3];

    // An unsupported shape stops all user traffic instead of aliasing into the array.
    always_comb begin
        cfgBad = 1'b0;
        if (wSel[0] > block_memory_pkg::SEL_X36 || wSel[1] > block_memory_pkg::SEL_X36) begin
            cfgBad = 1'b1;
        end
        if (memMode == block_memory_pkg::MODE_TRUE_DUAL
            && (wSel[0] == block_memory_pkg::SEL_X36 || wSel[1] == block_memory_pkg::SEL_X36)) begin
            cfgBad = 1'b1;
        end
        if (ctrl_reg[`CTRL_MODE_LSB +: 2] == 2'b11) begin
            cfgBad = 1'b1;
        end
        if (wMode[0] == 2'b11 || wMode[1] == 2'b11) begin
            cfgBad = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (apbWrite && paddr == `REG_CTRL) begin
            ctrl_reg <= pwdata & `CTRL_MASK;
        end
    end

    // The loader fills the array one 36-bit word at a time; writing the high 4 bits triggers the write.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loadAddr_reg <= 8'h00;
            loadLo_reg <= 32'h0000_0000;
        end else begin
            if (apbWrite && paddr == `REG_LOAD_ADDR) begin
                loadAddr_reg <= pwdata[7:0];
            end
            if (loadFire) begin
                loadAddr_reg <= loadAddr_reg + 8'h01;
            end
            if (apbWrite && paddr == `REG_LOAD_LO) begin
                loadLo_reg <= pwdata;
            end
        end
    end

    // Sticky collision flag: a new collision wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            collide_reg <= 1'b0;
        end else if (collide) begin
            collide_reg <= 1'b1;
        end else if (apbWrite && paddr == `REG_STATUS && pwdata[`STAT_COLLIDE_BIT]) begin
            collide_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read side

    assign pready = 1'b1;
    assign pslverr = psel && penable && !regHit(paddr);

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `REG_CTRL: prdata = ctrl_reg;
                `REG_STATUS: begin
                    prdata[`STAT_CFG_BAD_BIT] = cfgBad;
                    prdata[`STAT_COLLIDE_BIT] = collide_reg;
                end
                `REG_LOAD_ADDR: prdata = {24'h00_0000, loadAddr_reg};
                `REG_LOAD_LO: prdata = loadLo_reg;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ports

    logic [1:0] clrPort;
    logic [1:0] arrEn;
    logic [1:0] arrWe;
    logic [1:0][7:0] arrAddr;
    logic [1:0][35:0] arrMask;
    logic [1:0][35:0] arrData;
    block_memory_pkg::writeMode_t [1:0] arrMode;
    logic [1:0][35:0] arrRdata;

    assign clrPort[0] = portAOutputReset || !reset_n;
    assign clrPort[1] = portBOutputReset || !reset_n;
    assign collide = arrEn[0] && arrEn[1] && (arrWe[0] || arrWe[1]) && arrAddr[0] == arrAddr[1];

    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam bit IS_B = (p == 1);
        block_memory_pkg::portReq_t req_reg;
        logic [5:0] width_reg;
        logic [5:0] off_reg;
        logic upd_reg;
        logic [35:0] out_reg;
        logic outValid_reg;
        logic allowRd;
        logic allowWr;
        logic userRd;
        logic userWe;
        logic [5:0] width;
        logic [12:0] addrIn;
        logic [18:0] bitAddr;
        logic [5:0] off;
        logic [35:0] extracted;
        logic loadHere;
        logic updNext;

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                req_reg <= '0;
            end else begin
                req_reg <= portReq[p];
            end
        end

        // Port A only writes and port B only reads in pseudo dual mode; port B sleeps in single mode.
        assign allowRd = !cfgBad && (IS_B ? memMode != block_memory_pkg::MODE_SINGLE
                                          : memMode != block_memory_pkg::MODE_PSEUDO_DUAL);
        assign allowWr = !cfgBad && !romMode
            && (!IS_B || memMode == block_memory_pkg::MODE_TRUE_DUAL);
        assign userRd = req_reg.en && !req_reg.we && allowRd;
        assign userWe = req_reg.en && req_reg.we && allowWr;
        assign loadHere = !IS_B && loadFire;

        assign width = widthOf(wSel[p]);
        assign addrIn = req_reg.addr & depthMask(wSel[p]);
        assign bitAddr = 19'(addrIn) * 19'(width);
        assign off = 6'(bitAddr % 19'(`ARRAY_WORD_BITS));

        // The loader borrows port A for one cycle; a user access there is dropped.
        assign arrEn[p] = loadHere || userRd || userWe;
        assign arrWe[p] = loadHere || userWe;
        assign arrAddr[p] = loadHere ? loadAddr_reg : 8'(bitAddr / 19'(`ARRAY_WORD_BITS));
        assign arrMask[p] = loadHere ? {36{1'b1}} : lowMask(width) << off;
        assign arrData[p] = loadHere ? {pwdata[`LOAD_HI_BITS-1:0], loadLo_reg}
                                     : (req_reg.wdata & lowMask(width)) << off;
        assign arrMode[p] = loadHere ? block_memory_pkg::WM_NORMAL : wMode[p];

        // Width and offset of the last word shown are kept with the latch, so a released address
        // or a new width setting cannot reshuffle a word that has already been presented.
        assign updNext = !loadHere && (userRd || (userWe && wMode[p] != block_memory_pkg::WM_NORMAL));

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                width_reg <= `WIDTH_X1;
                off_reg <= 6'h00;
                upd_reg <= 1'b0;
            end else begin
                upd_reg <= updNext;
                if (updNext) begin
                    width_reg <= width;
                    off_reg <= off;
                end
            end
        end

        assign extracted = (arrRdata[p] >> off_reg) & lowMask(width_reg);

        always_ff @(posedge clk or posedge clrPort[p]) begin
            if (clrPort[p]) begin
                out_reg <= '0;
                outValid_reg <= 1'b0;
            end else begin
                out_reg <= extracted;
                outValid_reg <= upd_reg;
            end
        end

        assign dataOut[p] = outRegEn[p] ? out_reg : extracted;
        assign dataValid[p] = outRegEn[p] ? outValid_reg : upd_reg;

        a_bypass_read: assert property (!outRegEn[p] && userRd && !clrPort[p] ##1 !outRegEn[p]
            |-> dataValid[p])
            else $error("bypass read data not valid one cycle after the access");
        a_registered_read: assert property (outRegEn[p] && userRd ##1 outRegEn[p] && !clrPort[p]
            ##1 outRegEn[p] && !clrPort[p] |-> dataValid[p] && dataOut[p] == $past(extracted))
            else $error("registered read data not valid two cycles after the access");
        a_input_capture: assert property (portReq[p].en && portReq[p].we && allowWr
            ##1 allowWr && !loadHere |-> arrWe[p] && req_reg.wdata == $past(portReq[p].wdata)
            && req_reg.addr == $past(portReq[p].addr))
            else $error("write did not reach the array from the input register");
        a_bit_order: assert property (arrEn[p] && !loadHere
            |-> 19'(arrAddr[p]) * 19'(`ARRAY_WORD_BITS) + 19'(off) == 19'(addrIn) * 19'(width))
            else $error("word placement breaks the bit ordering");
        a_local_clear: assert property (disable iff (1'b0) clrPort[p] |-> dataOut[p] == '0)
            else $error("output not cleared by its port reset");
        a_rom_no_write: assert property (romMode && !loadHere |-> !arrWe[p])
            else $error("array written while writes are disabled");
        // In bypass the output may only move on a cycle that also raises its valid flag.
        a_output_hold: assert property (!outRegEn[p] && !clrPort[p] ##1 !outRegEn[p] && !clrPort[p]
            && !dataValid[p] |-> $stable(dataOut[p]))
            else $error("bypass output moved without a latch update");
    end

    a_global_clear: assert property (disable iff (1'b0) !reset_n |-> dataOut[0] == '0 && dataOut[1] == '0)
        else $error("chip-wide reset did not clear both outputs");
    a_single_port: assert property (memMode == block_memory_pkg::MODE_SINGLE |-> !arrEn[1])
        else $error("port B active in single-port mode");
    a_pseudo_roles: assert property (memMode == block_memory_pkg::MODE_PSEUDO_DUAL
        |-> !arrWe[1] && (!arrEn[0] || arrWe[0]))
        else $error("pseudo dual-port roles violated");
    a_dual_width: assert property (memMode == block_memory_pkg::MODE_TRUE_DUAL
        && wSel[1] == block_memory_pkg::SEL_X36 |-> !arrEn[1] && !arrEn[0] || loadFire)
        else $error("true dual-port ran at x36");
    a_collide_flag: assert property (collide |=> collide_reg)
        else $error("collision not recorded");
    a_collide_clear: assert property (apbWrite && paddr == `REG_STATUS && pwdata[`STAT_COLLIDE_BIT]
        && !collide |=> !collide_reg)
        else $error("collision flag not cleared by software");
    // The loader walks the array on its own, so a block of words needs a single start address.
    a_load_advance: assert property (loadFire |=> loadAddr_reg == $past(loadAddr_reg) + 8'h01)
        else $error("load address did not advance after a word");

    ////////////////////////////////////////////////////////////////////////////
    // Array of 256 words of 36 bits, 9216 bits in all

    block_memory_array #(
        .WORDS(`ARRAY_WORDS),
        .BITS(`ARRAY_WORD_BITS)
    ) u_array (
        .clk(clk),
        .clear(clrPort),
        .en(arrEn),
        .we(arrWe),
        .addr(arrAddr),
        .mask(arrMask),
        .wdata(arrData),
        .wMode(arrMode),
        .rdata(arrRdata)
    );

endmodule : embedded_block_memory

// ### verif/user_port_model.sv
////////////////////////////////////////////////////////////////////////////////
// Fabric-side user logic for one memory port.
module user_port_model (
    // Clock and read side of the port
    input wire logic clk,
    input wire logic [35:0] dataOut,
    input wire logic dataValid,
    // Request towards the memory
    output block_memory_pkg::portReq_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req = '0;
    end

    // One access at a time per port; the two ports can still meet on one word when driven together.
    // Released lines carry the inverse, so a stale value never reads as live.
    task automatic access(input logic we, input logic [12:0] addr, input logic [35:0] wd,
                          output int lat, output logic [35:0] rd);
        @(posedge clk);
        req <= '{en: 1'b1, we: we, addr: addr, wdata: wd};
        @(posedge clk);
        req <= '{en: 1'b0, we: ~we, addr: ~addr, wdata: ~wd};
        lat = 0;
        rd = '0;
        for (int i = 1; i <= 4 && lat == 0; i++) begin
            @(posedge clk);
            #1;
            if (dataValid === 1'b1) begin
                lat = i;
                rd = dataOut;
            end
        end
    endtask : access
endmodule : user_port_model

// ### verif/tb_embedded_block_memory.sv
`include "block_memory_params.svh"

module tb_embedded_block_memory;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic portAOutputReset = 1'b0;
    logic portBOutputReset = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    block_memory_pkg::portReq_t reqA;
    block_memory_pkg::portReq_t reqB;
    logic [1:0][35:0] dataOut;
    logic [1:0] dataValid;
    logic [31:0] rd;
    logic err;
    logic [35:0] got;
    int lat;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam logic [35:0] PAT = 36'hC_3A5F_0E69;

    embedded_block_memory #(.APB_AW(8)) u_dut (
        .clk(clk), .reset_n(reset_n),
        .portAOutputReset(portAOutputReset), .portBOutputReset(portBOutputReset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portReq({reqB, reqA}), .dataOut(dataOut), .dataValid(dataValid)
    );
    user_port_model u_portA (.clk(clk), .dataOut(dataOut[0]), .dataValid(dataValid[0]), .req(reqA));
    user_port_model u_portB (.clk(clk), .dataOut(dataOut[1]), .dataValid(dataValid[1]), .req(reqB));

    initial begin
        forever #5 clk = ~clk;
    end

    // The whole run needs about 230 cycles; the ceiling leaves ample slack.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            $display("MISMATCH at %0t: run did not finish", $time);
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] g, input logic [35:0] e, input string msg);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, g, e);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic rom, input logic oa,
                                        input logic [1:0] wa, input logic [2:0] sa, input logic [2:0] sb);
        return {17'h0_0000, sb, sa, 2'h0, wa, 1'b0, oa, rom, m};
    endfunction : ctl

    task automatic load(input logic [7:0] idx, input logic [35:0] v);
        apb(1'b1, `REG_LOAD_ADDR, {24'h00_0000, idx});
        apb(1'b1, `REG_LOAD_LO, v[31:0]);
        apb(1'b1, `REG_LOAD_HI, {28'h000_0000, v[35:32]});
    endtask : load

    task automatic acc(input int p, input logic we, input logic [12:0] a, input logic [35:0] wd);
        if (p == 0) u_portA.access(we, a, wd, lat, got);
        else u_portB.access(we, a, wd, lat, got);
    endtask : acc

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, `REG_CTRL, 32'h0000_0000);
        check({4'h0, rd}, 36'h0, "ctrl reset");
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({35'h0, err}, 36'h1, "unmapped err");
        $display("test regs done");
    endtask : t_regs

    task automatic t_rom();
        load(8'h00, 36'h9_8765_4321);
        load(8'hFF, 36'hA_BCDE_F012);
        apb(1'b1, `REG_CTRL, ctl(2'h0, 1'b1, 1'b0, 2'h0, 3'h5, 3'h0));
        acc(0, 1'b0, 13'h0, 36'h0);
        check(got, 36'h9_8765_4321, "rom word 0");
        check(36'(lat), 36'h1, "bypass latency");
        acc(0, 1'b0, 13'hFF, 36'h0);
        check(got, 36'hA_BCDE_F012, "rom last word");
        acc(0, 1'b1, 13'h0, 36'h0);
        acc(0, 1'b0, 13'h0, 36'h0);
        check(got, 36'h9_8765_4321, "rom write blocked");
        apb(1'b1, `REG_CTRL, ctl(2'h0, 1'b1, 1'b1, 2'h0, 3'h5, 3'h0));
        acc(0, 1'b0, 13'hFF, 36'h0);
        check(36'(lat), 36'h2, "registered latency");
        check(got, 36'hA_BCDE_F012, "registered data");
        $display("test rom done");
    endtask : t_rom

    task automatic t_widths();
        int ws[6] = '{1, 2, 4, 9, 18, 36};
        apb(1'b1, `REG_CTRL, ctl(2'h2, 1'b0, 1'b0, 2'h0, 3'h5, 3'h5));
        acc(0, 1'b1, 13'h1, PAT);
        // Bit address 36 is the first bit of word one at every width.
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `REG_CTRL, ctl(2'h2, 1'b0, 1'b0, 2'h0, 3'h5, 3'(i)));
            acc(1, 1'b0, 13'(36 / ws[i]), 36'h0);
            check(got, PAT & ((36'h1 << ws[i]) - 36'h1), "width read");
        end
        apb(1'b1, `REG_CTRL, ctl(2'h1, 1'b0, 1'b0, 2'h0, 3'h4, 3'h5));
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check({35'h0, rd[`STAT_CFG_BAD_BIT]}, 36'h1, "dual x36 refused");
        $display("test widths done");
    endtask : t_widths

    task automatic t_wmodes();
        for (int m = 0; m < 3; m++) begin
            load(8'h03, 36'h5_0000_0000 + 36'(m));
            apb(1'b1, `REG_CTRL, ctl(2'h0, 1'b0, 1'b0, 2'(m), 3'h5, 3'h0));
            acc(0, 1'b0, 13'h3, 36'h0);
            acc(0, 1'b1, 13'h3, 36'h6_0000_0000 + 36'(m));
            if (m == 0) begin
                check(36'(lat), 36'h0, "normal no output");
                check(dataOut[0], 36'h5_0000_0000, "normal holds");
            end else if (m == 1) begin
                check(got, 36'h6_0000_0001, "write through");
            end else begin
                check(got, 36'h5_0000_0002, "read before write");
            end
            acc(0, 1'b0, 13'h3, 36'h0);
            check(got, 36'h6_0000_0000 + 36'(m), "write stored");
        end
        $display("test wmodes done");
    endtask : t_wmodes

    task automatic t_resets();
        load(8'h00, 36'h3_0000_1234);
        apb(1'b1, `REG_CTRL, ctl(2'h1, 1'b0, 1'b0, 2'h0, 3'h4, 3'h4));
        acc(0, 1'b0, 13'h0, 36'h0);
        acc(1, 1'b0, 13'h1, 36'h0);
        check(got, 36'hC000, "x18 upper half");
        // Checked one ns after assertion, before any edge could act.
        @(posedge clk);
        portAOutputReset <= 1'b1;
        #1;
        check(dataOut[0], 36'h0, "port A cleared");
        check(dataOut[1], 36'hC000, "port B kept");
        @(posedge clk);
        portAOutputReset <= 1'b0;
        acc(0, 1'b0, 13'h0, 36'h0);
        @(posedge clk);
        portBOutputReset <= 1'b1;
        #1;
        check(dataOut[1], 36'h0, "port B cleared");
        check(dataOut[0], 36'h1234, "port A kept");
        @(posedge clk);
        portBOutputReset <= 1'b0;
        acc(1, 1'b0, 13'h1, 36'h0);
        // Both ports hit word zero at once; only the flag is judged, never the read data.
        fork
            acc(0, 1'b1, 13'h0, 36'h0);
            acc(1, 1'b0, 13'h0, 36'h0);
        join
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check({35'h0, rd[`STAT_COLLIDE_BIT]}, 36'h1, "collision flagged");
        apb(1'b1, `REG_STATUS, 32'h0000_0002);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check({35'h0, rd[`STAT_COLLIDE_BIT]}, 36'h0, "collision cleared");
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        check(dataOut[0], 36'h0, "chip reset clears A");
        check(dataOut[1], 36'h0, "chip reset clears B");
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0000_0000);
        check({4'h0, rd}, 36'h0, "ctrl after reset");
        $display("test resets done");
    endtask : t_resets

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_rom();
        t_widths();
        t_wmodes();
        t_resets();
        summarize();
    end
endmodule : tb_embedded_block_memory
